/* File: dv/spfc_checker.sv */
// Concurrent checks on the ports of the framed serial port block
`timescale 1ns/1ps
`default_nettype none
module spfc_checker (
  input wire core_clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire pps_sdo_route,
  input wire sclk_o,
  input wire sdo_oe,
  input wire ss_o,
  input wire ss_oe
);
  // ****
  // Register mirrors
  // ****
  // Full lanes assumed; outputs lag a write by two edges, hence the age count
  logic [31:0] ctl_q, aux_q;
  logic [1:0] age_q;
  logic wr_w, idle_w, set_w;
  assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign idle_w = ctl_q[6] | aux_q[16];
  assign set_w = age_q[1];
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q <= 32'h0;
      aux_q <= 32'h0;
      age_q <= 2'h0;
    end else begin
      if (wr_w && wb_adr_i == 4'h0) ctl_q <= wb_dat_i;
      if (wr_w && wb_adr_i == 4'hC) aux_q <= wb_dat_i;
      if (wr_w && (wb_adr_i == 4'h0 || wb_adr_i == 4'hC)) age_q <= 2'h0;
      else age_q <= age_q + {1'b0, age_q != 2'h3};
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_prompt: assert property (wr_w && wb_adr_i != 4'h4 |=> wb_ack_o)
    else $error("write not acked next cycle");
  a_gap_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[22:18] == 5'h00)
    else $error("unused control bits read nonzero");
  a_route_wins: assert property (sdo_oe == pps_sdo_route)
    else $error("serial out enable ignores routing");
  a_sync_input: assert property (ctl_q[31] && ctl_q[30] && set_w |-> !ss_oe)
    else $error("input sync pin driven");
  a_sync_drive: assert property (ctl_q[31] && !ctl_q[30] && ctl_q[15] && ctl_q[5] && set_w |-> ss_oe)
    else $error("output sync pin not driven");
  a_idle_clock: assert property (!ctl_q[15] && set_w |-> sclk_o == idle_w)
    else $error("serial clock off idle level");
  a_auto_level: assert property (!ctl_q[31] && ctl_q[28] && ctl_q[15] && ctl_q[5] && set_w
    && sclk_o != idle_w |-> ss_oe && ss_o == ctl_q[29])
    else $error("select pin wrong during transfer");
  c_sync_out: cover property ($rose(ss_oe));
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_clock: cover property (sclk_o != $past(sclk_o));
endmodule // spfc_checker
bind spfc_ctrl spfc_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pps_sdo_route(pps_sdo_route), .sclk_o(sclk_o), .sdo_oe(sdo_oe), .ss_o(ss_o), .ss_oe(ss_oe));
`default_nettype wire

/* File: dv/spfc_ctrl_tb.sv */
// Self-checking bench of the framed serial port block
`timescale 1ns/1ps
`default_nettype none
module spfc_ctrl_tb;
  logic core_clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q, c, e;
  logic ack, ref_tick = 1'b0, ref_en = 1'b1, route = 1'b1, sync_lvl = 1'b0, pol_t = 1'b1;
  logic pb2 = 1'b1, ipol = 1'b0, clr = 1'b0;
  logic [3:0] sel = 4'hF, lanes = 4'hF;
  logic sclk, sdo, sdo_oe, sdi, ss_i, ss_o, ss_oe, act_q = 1'b0;
  logic [7:0] rx_byte, rx_count, n0;
  int fails = 0, comparisons = 0, pulses = 0, act_cyc = 0, cyc_cnt = 0;
  spfc_ctrl #(.DATA_W(8), .FIFO_DEPTH(16), .FIFO_AW(4)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ref_clk_tick(ref_tick), .pb2_tick(pb2), .pps_sdo_route(route), .sclk_o(sclk),
    .sdo_o(sdo), .sdo_oe(sdo_oe), .sdi_i(sdi), .ss_i(ss_i), .ss_o(ss_o), .ss_oe(ss_oe));
  spfc_partner u_far (.core_clk(core_clk), .sclk_o(sclk), .sdo_o(sdo), .ss_o(ss_o),
    .ss_oe(ss_oe), .idle_pol(ipol), .sync_lvl(sync_lvl), .clr(clr), .sdi_i(sdi), .ss_i(ss_i),
    .rx_byte(rx_byte), .rx_count(rx_count));
  // ****
  // Clock, ticks, sync monitor, timeout
  // ****
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ref_tick <= ref_en & ~ref_tick;
    act_q <= ss_oe && ss_o === pol_t;
    if (ss_oe && ss_o === pol_t) act_cyc++;
    if (ss_oe && ss_o === pol_t && !act_q) pulses++;
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      fails++;
      end_of_test();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1) @(posedge core_clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    comparisons++;
    if (g !== ex) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] ex);
    wb(1'b0, a, 32'h0);
    chk(nm, ex, q);
  endtask
  // Busy clear and buffer empty; the bench timeout bounds the poll
  task automatic idle();
    do wb(1'b0, 4'h8, 32'h0); while (q[3] !== 1'b0 || q[1] !== 1'b1);
  endtask
  task automatic arm();
    repeat (3) @(posedge core_clk);
    pulses = 0;
    act_cyc = 0;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    chk("select pin at reset", 32'h1, {30'h0, ss_oe, ss_o});
    rchk("ctrl reset", 4'h0, 32'h0);
    rchk("aux reset", 4'hC, 32'h0);
    rchk("status reset", 4'h8, 32'h2);
    rchk("unmapped", 4'h2, 32'h0);
    wb(1'b1, 4'h0, 32'hFFFF_7FFF);
    rchk("ctrl gaps", 4'h0, 32'hFF83_3FFF);
    lanes = 4'h1;
    wb(1'b1, 4'h0, 32'h0);
    lanes = 4'hF;
    rchk("byte lane write", 4'h0, 32'hFF83_3F00);
    wb(1'b1, 4'h0, 32'h0081_0000);
    wb(1'b1, 4'h0, 32'h0081_8000);
    wb(1'b1, 4'h0, 32'h0000_8000);
    rchk("ctrl while on", 4'h0, 32'h0081_8000);
    wb(1'b1, 4'h0, 32'h0);
    rchk("ctrl turning off", 4'h0, 32'h0081_0000);
    wb(1'b1, 4'h0, 32'h0);
    rchk("ctrl while off", 4'h0, 32'h0);
    wb(1'b1, 4'hC, 32'h0001_0001);
    repeat (3) @(posedge core_clk);
    chk("audio idle clock", 32'h1, {31'h0, sclk});
    wb(1'b1, 4'hC, 32'h1);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    for (c = 0; c < 2; c++) begin
      route <= c[0];
      @(posedge core_clk);
      chk("serial out enable", {31'h0, c[0]}, {31'h0, sdo_oe});
    end
    ref_en <= 1'b0;
    wb(1'b1, 4'h0, 32'h1000_8020);
    wb(1'b1, 4'h4, 32'h5A);
    idle();
    ref_en <= 1'b1;
    chk("bits on wire", 32'h5A, {24'h0, rx_byte});
    rchk("received word", 4'h4, 32'hA5);
    // Every sync count code, reserved ones acting as one character
    for (c = 0; c < 8; c++) begin
      wb(1'b1, 4'h0, 32'hA000_8020 | (c << 24));
      arm();
      repeat (32) wb(1'b1, 4'h4, 32'h3C);
      idle();
      e = (c > 5) ? 32'd32 : 32'd32 >> c;
      chk("sync pulses", e, pulses);
      chk("sync cycles", e * 4, act_cyc);
    end
    pol_t <= 1'b0;
    wb(1'b1, 4'h0, 32'h8900_8020);
    arm();
    repeat (4) wb(1'b1, 4'h4, 32'h3C);
    idle();
    chk("wide pulses", 32'd2, pulses);
    chk("wide cycles", 32'd64, act_cyc);
    chk("sync idle level", 32'h1, {31'h0, ss_o});
    wb(1'b1, 4'h0, 32'hE000_8020);
    n0 = rx_count;
    wb(1'b1, 4'h4, 32'h96);
    repeat (40) @(posedge core_clk);
    chk("wait for sync", {24'h0, n0}, {24'h0, rx_count});
    chk("sync released", 32'h0, {31'h0, ss_oe});
    sync_lvl <= 1'b1;
    idle();
    sync_lvl <= 1'b0;
    chk("slave framed byte", 32'h96, {24'h0, rx_byte});
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b1, 4'h0, 32'h0081_0000);
    ref_en <= 1'b0;
    wb(1'b1, 4'h0, 32'h0081_8020);
    n0 = rx_count;
    repeat (17) wb(1'b1, 4'h4, 32'h69);
    wb(1'b0, 4'h8, 32'h0);
    chk("buffer full", 32'h20C, q & 32'h3FE);
    ref_en <= 1'b1;
    idle();
    chk("drained count", {24'h0, n0} + 32'd17, {24'h0, rx_count});
    end_of_test();
  end
endmodule // spfc_ctrl_tb
`default_nettype wire

/* File: dv/spfc_partner.sv */
// External serial slave model facing the framed port
`timescale 1ns/1ps
`default_nettype none
module spfc_partner (
  input wire logic core_clk,
  input wire logic sclk_o,
  input wire logic sdo_o,
  input wire logic ss_o,
  input wire logic ss_oe,
  input wire logic idle_pol,
  input wire logic sync_lvl,
  input wire logic clr,
  output logic sdi_i,
  output logic ss_i,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_count
);
  // ****
  // Shift logic
  // ****
  logic [7:0] sh_q = 8'h00;
  logic [7:0] tx_q = 8'hA5;
  logic [2:0] bit_q = 3'h0;
  logic sclk_q = 1'b0;
  // Pin level: the port when it drives, else the sync source
  assign ss_i = ss_oe ? ss_o : sync_lvl;
  assign sdi_i = tx_q[7];
  initial begin
    rx_byte = 8'h00;
    rx_count = 8'h00;
  end
  always @(posedge core_clk) begin
    sclk_q <= sclk_o;
    // Clear drops edges made while the idle level was being changed
    if (clr) begin
      bit_q <= 3'h0;
      tx_q <= 8'hA5;
    end else begin
      if (sclk_o != sclk_q && sclk_o != idle_pol) begin
        sh_q <= {sh_q[6:0], sdo_o};
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) rx_byte <= {sh_q[6:0], sdo_o};
        if (bit_q == 3'h7) rx_count <= rx_count + 8'h01;
      end
      // Reply reloads at each byte start; inverted bits fill in behind it
      if (sclk_o != sclk_q && sclk_o == idle_pol) tx_q <= (bit_q == 3'h0) ? 8'hA5 : {tx_q[6:0], ~tx_q[7]};
    end
  end
endmodule // spfc_partner
`default_nettype wire

/* File: pkg/spfc_consts.vh */
// Constants of the framed serial port control block
`ifndef SPFC_CONSTS_VH
`define SPFC_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define SPFC_ADR_CTRL 4'h0
`define SPFC_ADR_DATA 4'h4
`define SPFC_ADR_STAT 4'h8
`define SPFC_ADR_AUX 4'hC
`define SPFC_CTRL_RST 32'h0000_0000
`define SPFC_CTRL_WMASK 32'hFF83_BFFF
`define SPFC_AUX_RST 32'h0000_0000
`define SPFC_AUX_WMASK 32'h0001_FFFF
`define SPFC_LOCK_MASK 32'h0081_0000

// ****************************************
// Control and aux fields
// ****************************************
`define SPFC_B_FRAMED 31
`define SPFC_B_SYNC_DIR 30
`define SPFC_B_SYNC_POL 29
`define SPFC_B_AUTO_SEL 28
`define SPFC_B_PULSE_W 27
`define SPFC_F_COUNT 26:24
`define SPFC_B_CLK_SEL 23
`define SPFC_B_ENH_BUF 16
`define SPFC_B_ON 15
`define SPFC_B_EDGE 8
`define SPFC_B_IDLE_POL 6
`define SPFC_B_MASTER 5
`define SPFC_F_DIV 15:0
`define SPFC_B_AUDIO 16

// ****************************************
// Shifter states
// ****************************************
`define SPFC_ST_IDLE 2'h0
`define SPFC_ST_WAIT 2'h1
`define SPFC_ST_SHIFT 2'h2

`endif

/* File: src/spfc_baud.v */
// Baud generator: half-period ticks from the selected source tick
`timescale 1ns/1ps
`default_nettype none
module spfc_baud #(
  parameter DIV_W = 16
) (
  input wire core_clk,
  input wire sys_rst,
  input wire run,
  input wire src_sel,
  input wire ref_tick,
  input wire pb2_tick,
  input wire [DIV_W-1:0] divisor,
  output wire half_tick
);
  reg [DIV_W-1:0] cnt_q;
  wire src_tick;

  // Reference clock output or bus clock two feeds the count
  assign src_tick = src_sel ? ref_tick : pb2_tick;
  assign half_tick = run & src_tick & (cnt_q == divisor);

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= {DIV_W{1'b0}};
    end else if (!run || half_tick) begin
      cnt_q <= {DIV_W{1'b0}};
    end else if (src_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // spfc_baud
`default_nettype wire

/* File: src/spfc_ctrl.v */
// Framed serial port: control registers, Wishbone slave and master shifter
//
// Implementation choices: the register offsets and register access over Wishbone.
`include "spfc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module spfc_ctrl #(
  parameter DATA_W = 8,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire core_clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ref_clk_tick,
  input wire pb2_tick,
  input wire pps_sdo_route,
  output reg sclk_o,
  output wire sdo_o,
  output wire sdo_oe,
  input wire sdi_i,
  input wire ss_i,
  output reg ss_o,
  output reg ss_oe
);
  // ****************************************
  // Helpers
  // ****************************************
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    input [31:0] wmask;
    reg [31:0] lane;
    begin
      lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
      merge = (old_v & ~lane) | (new_v & lane);
    end
  endfunction

  // Last index of a character group
  function [4:0] group_last;
    input [2:0] code;
    begin
      case (code)
        3'h1: group_last = 5'h01;
        3'h2: group_last = 5'h03;
        3'h3: group_last = 5'h07;
        3'h4: group_last = 5'h0F;
        3'h5: group_last = 5'h1F;
        default: group_last = 5'h00;
      endcase
    end
  endfunction

  // ****************************************
  // Registers and decode
  // ****************************************
  reg [31:0] ctrl_q;
  reg [31:0] aux_q;
  reg [DATA_W-1:0] rx_data_q;
  reg rx_valid_q;
  reg overrun_q;
  reg [1:0] state_q;
  reg [DATA_W-1:0] tx_sh_q;
  reg [DATA_W-1:0] rx_sh_q;
  reg [4:0] bit_q;
  reg phase_q;
  reg [4:0] grp_q;
  reg sync_char_q;

  wire req;
  wire wr_ctrl;
  wire wr_aux;
  wire wr_data;
  wire rd_data;
  wire push_ok;
  wire ack_d;
  wire [31:0] ctrl_new;
  wire [31:0] rd_mux;

  wire on = ctrl_q[`SPFC_B_ON];
  wire framed = ctrl_q[`SPFC_B_FRAMED];
  wire sync_in = ctrl_q[`SPFC_B_SYNC_DIR];
  wire sync_pol = ctrl_q[`SPFC_B_SYNC_POL];
  wire auto_sel = ctrl_q[`SPFC_B_AUTO_SEL];
  wire pulse_w = ctrl_q[`SPFC_B_PULSE_W];
  wire master = ctrl_q[`SPFC_B_MASTER];
  wire enh_buf = ctrl_q[`SPFC_B_ENH_BUF];
  wire idle_pol = ctrl_q[`SPFC_B_IDLE_POL] | aux_q[`SPFC_B_AUDIO];
  wire edge_late = ctrl_q[`SPFC_B_EDGE] & ~framed;

  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [DATA_W-1:0] fifo_out_data;
  wire [FIFO_AW:0] fifo_level;
  wire fifo_pop;
  wire half_tick;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr_ctrl = req & wb_we_i & (wb_adr_i == `SPFC_ADR_CTRL);
  assign wr_aux = req & wb_we_i & (wb_adr_i == `SPFC_ADR_AUX);
  assign wr_data = req & wb_we_i & (wb_adr_i == `SPFC_ADR_DATA);
  assign rd_data = req & ~wb_we_i & (wb_adr_i == `SPFC_ADR_DATA);

  // Without the enhanced buffer only one word may wait
  assign push_ok = fifo_in_ready & (enh_buf | (fifo_level == {(FIFO_AW+1){1'b0}}));

  // Data writes stall while the port runs and the buffer is full
  assign ack_d = req & ~wb_ack_o & ~(wr_data & on & ~push_ok);

  // Bits 22..18 are masked out of every write
  assign ctrl_new = merge(ctrl_q, wb_dat_i, wb_sel_i, `SPFC_CTRL_WMASK);

  assign rd_mux = (wb_adr_i == `SPFC_ADR_CTRL) ? ctrl_q :
                  (wb_adr_i == `SPFC_ADR_AUX) ? aux_q :
                  (wb_adr_i == `SPFC_ADR_DATA) ? {{(32-DATA_W){1'b0}}, rx_data_q} :
                  (wb_adr_i == `SPFC_ADR_STAT) ?
                    {{(26-FIFO_AW){1'b0}}, fifo_level, overrun_q,
                     (state_q != `SPFC_ST_IDLE), ~fifo_in_ready,
                     ~fifo_out_valid, rx_valid_q} :
                  32'h0000_0000;

  // ****************************************
  // Wishbone slave
  // ****************************************
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_q <= `SPFC_CTRL_RST;
      aux_q <= `SPFC_AUX_RST;
    end else begin
      wb_ack_o <= ack_d;
      if (ack_d & ~wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
      if (ack_d & wr_ctrl) begin
        // Clock select and buffer enable hold while the port is on
        if (on) begin
          ctrl_q <= (ctrl_new & ~`SPFC_LOCK_MASK) | (ctrl_q & `SPFC_LOCK_MASK);
        end else begin
          ctrl_q <= ctrl_new;
        end
      end
      if (ack_d & wr_aux) begin
        aux_q <= merge(aux_q, wb_dat_i, wb_sel_i, `SPFC_AUX_WMASK);
      end
    end
  end

  // ****************************************
  // Transmit buffer and baud source
  // ****************************************
  spfc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(ack_d & wr_data & on & push_ok),
    .in_ready(fifo_in_ready),
    .in_data(wb_dat_i[DATA_W-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  spfc_baud #(
    .DIV_W(16)
  ) u_baud (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(state_q == `SPFC_ST_SHIFT),
    .src_sel(ctrl_q[`SPFC_B_CLK_SEL]),
    .ref_tick(ref_clk_tick),
    .pb2_tick(pb2_tick),
    .divisor(aux_q[`SPFC_F_DIV]),
    .half_tick(half_tick)
  );

  // ****************************************
  // Character framing and shifter
  // ****************************************
  // Shifter only drains while the port is an enabled master
  assign fifo_pop = (state_q == `SPFC_ST_IDLE) & on & master & fifo_out_valid;

  // Legacy disable bits are stored only; pin routing decides
  assign sdo_oe = pps_sdo_route;
  assign sdo_o = tx_sh_q[DATA_W-1];

  wire [DATA_W-1:0] rx_in = {rx_sh_q[DATA_W-2:0], sdi_i};
  wire last_bit = (bit_q == DATA_W[4:0] - 5'h01);
  wire group_start = framed & (grp_q == 5'h00);
  wire sync_seen = (ss_i == sync_pol);
  wire busy = (state_q != `SPFC_ST_IDLE);
  // One character wide or one serial clock wide
  wire sync_act = sync_char_q & (state_q == `SPFC_ST_SHIFT) &
                  (pulse_w | (bit_q == 5'h00));
  wire rx_take = (state_q == `SPFC_ST_SHIFT) & half_tick & phase_q & last_bit;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= `SPFC_ST_IDLE;
      tx_sh_q <= {DATA_W{1'b0}};
      rx_sh_q <= {DATA_W{1'b0}};
      bit_q <= 5'h00;
      phase_q <= 1'b0;
      grp_q <= 5'h00;
      sync_char_q <= 1'b0;
      sclk_o <= 1'b0;
    end else begin
      case (state_q)
        `SPFC_ST_IDLE: begin
          sclk_o <= idle_pol;
          bit_q <= 5'h00;
          phase_q <= 1'b0;
          if (!framed) begin
            grp_q <= 5'h00;
          end
          if (fifo_pop) begin
            tx_sh_q <= fifo_out_data;
            sync_char_q <= group_start;
            if (framed) begin
              grp_q <= (grp_q >= group_last(ctrl_q[`SPFC_F_COUNT])) ?
                       5'h00 : grp_q + 5'h01;
            end
            // Slave sync waits for the partner's pulse at a group start
            if (group_start & sync_in) begin
              state_q <= `SPFC_ST_WAIT;
            end else begin
              state_q <= `SPFC_ST_SHIFT;
            end
          end
        end
        `SPFC_ST_WAIT: begin
          if (!on || !framed) begin
            state_q <= `SPFC_ST_IDLE;
          end else if (sync_seen) begin
            state_q <= `SPFC_ST_SHIFT;
          end
        end
        `SPFC_ST_SHIFT: begin
          if (!on) begin
            state_q <= `SPFC_ST_IDLE;
          end else if (half_tick) begin
            if (!phase_q) begin
              phase_q <= 1'b1;
              sclk_o <= ~idle_pol;
              if (!edge_late) begin
                rx_sh_q <= rx_in;
              end
            end else begin
              phase_q <= 1'b0;
              sclk_o <= idle_pol;
              if (edge_late) begin
                rx_sh_q <= rx_in;
              end
              tx_sh_q <= {tx_sh_q[DATA_W-2:0], 1'b0};
              if (last_bit) begin
                state_q <= `SPFC_ST_IDLE;
              end else begin
                bit_q <= bit_q + 5'h01;
              end
            end
          end
        end
        default: begin
          state_q <= `SPFC_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Receive word and flags
  // ****************************************
  // A new word landing in the read cycle keeps the flag set
  // Overrun set beats a clear written in the same cycle
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_data_q <= {DATA_W{1'b0}};
      rx_valid_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (ack_d & wr_ctrl & ~wb_dat_i[`SPFC_B_ON] & wb_sel_i[1]) begin
        overrun_q <= 1'b0;
      end
      if (rx_take) begin
        rx_data_q <= edge_late ? rx_in : rx_sh_q;
        rx_valid_q <= 1'b1;
        if (rx_valid_q & ~(ack_d & rd_data)) begin
          overrun_q <= 1'b1;
        end
      end else if (ack_d & rd_data) begin
        rx_valid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Slave select and frame sync pin
  // ****************************************
  // Sync and select levels both follow the polarity bit
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ss_o <= 1'b1;
      ss_oe <= 1'b0;
    end else if (on & framed) begin
      ss_oe <= ~sync_in;
      ss_o <= sync_act ? sync_pol : ~sync_pol;
    end else if (on & master & auto_sel) begin
      ss_oe <= 1'b1;
      ss_o <= busy ? sync_pol : ~sync_pol;
    end else begin
      ss_oe <= 1'b0;
      ss_o <= ~sync_pol;
    end
  end
endmodule // spfc_ctrl
`default_nettype wire

/* File: src/spfc_fifo.v */
// Transmit word FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spfc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign level = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // spfc_fifo
`default_nettype wire
